// [hdl/eeprom_host_pkg.sv]
// Constants for the parallel nonvolatile memory host controller
package eeprom_host_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 256;
   localparam int CLK_MHZ = 20;
   localparam int CLK_NS = 50;
   // Times in their own units, cycles derived from them
   localparam int POWERUP_READ_US = 100;
   localparam int POWERUP_WRITE_MS = 5;
   localparam int PROGRAM_CYCLE_MS = 10;
   localparam int BYTE_LOAD_MAX_US = 200;
   localparam int BYTE_LOAD_MIN_NS = 200;
   localparam int READ_ACCESS_NS = 350;
   localparam int STROBE_WIDTH_NS = 100;
   localparam int RECOVER_NS = 100;
   localparam int OE_SETUP_NS = 10;
   localparam int PUR_CYC = POWERUP_READ_US * CLK_MHZ;
   localparam int PUW_CYC = POWERUP_WRITE_MS * 1000 * CLK_MHZ;
   localparam int PROG_CYC = PROGRAM_CYCLE_MS * 1000 * CLK_MHZ;
   localparam int BLC_MAX_CYC = BYTE_LOAD_MAX_US * CLK_MHZ;
   localparam int BLC_MIN_CYC = (BYTE_LOAD_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int WP_CYC = (STROBE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int OES_CYC = (OE_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 24;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
endpackage : eeprom_host_pkg

// [hdl/eeprom_host.sv]
// Host controller that drives the byte-wide memory pins
`timescale 1ns/1ps
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int PUW_CYCLES = PUW_CYC,
   parameter int PROG_CYCLES = PROG_CYC
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_last,
   input wire logic req_poll,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic busy,
   output logic prog_done,
   output logic chip_select_n,
   output logic output_drive_enable_n,
   output logic write_strobe_n,
   output logic [ADDR_W-1:0] mem_address,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_in
);
   typedef enum logic [6:0] {
      S_PWRUP = 7'h01, S_IDLE = 7'h02, S_RD = 7'h04, S_WSET = 7'h08,
      S_WLOW = 7'h10, S_WHIGH = 7'h20, S_PROG = 7'h40
   } state_t;
   state_t state_q;
   logic [CNT_W-1:0] pwr_q, tm_q, gap_q;
   logic [ADDR_W-9:0] page_q;
   logic [8:0] nbytes_q;
   logic in_page_q, last_q;
   logic [DATA_W-1:0] s1_q, s2_q, s3_q, din_q;
   logic rd_ok, wr_ok, page_match, gap_expired;
   // Power-up delays gate reads and writes
   assign rd_ok = (pwr_q >= CNT_W'(PUR_CYC));
   assign wr_ok = (pwr_q >= CNT_W'(PUW_CYCLES));
   assign page_match = !in_page_q || (req_addr[ADDR_W-1:8] == page_q);
   // Margin leaves room for one poll read and the strobe lead before the device gives up
   assign gap_expired = in_page_q && gap_q >= CNT_W'(BLC_MAX_CYC - 2 * (WP_CYC + WPH_CYC) - RD_CYC - 4);
   // Ready only when idle, with or without an open page, for a compatible request
   always_comb
   begin
      req_ready = 1'b0;
      if (state_q == S_IDLE && req_valid)
      begin
         if (req_write)
            req_ready = wr_ok && page_match && !gap_expired && nbytes_q < 9'(PAGE_BYTES);
         else
            req_ready = rd_ok && !in_page_q || in_page_q && req_poll && !gap_expired;
      end
   end
   assign busy = (state_q != S_IDLE) || in_page_q;
   // Power-up counter saturates
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pwr_q <= '0;
      else if (clk_en && !(rd_ok && wr_ok))
         pwr_q <= pwr_q + 1'b1;
   end
   // Three-stage input sampler for read data
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         din_q <= '0;
      end
      else if (clk_en)
      begin
         s1_q <= data_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Accept a new byte only once the last two stages agree
         if (s2_q == s3_q)
            din_q <= s3_q;
      end
   end
   // Main sequencer
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= S_PWRUP;
         tm_q <= '0;
         gap_q <= '0;
         chip_select_n <= 1'b1;
         output_drive_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         mem_address <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
         page_q <= '0;
         nbytes_q <= '0;
         in_page_q <= 1'b0;
         last_q <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         prog_done <= 1'b0;
      end
      else if (clk_en)
      begin
         rsp_valid <= 1'b0;
         prog_done <= 1'b0;
         tm_q <= tm_q + 1'b1;
         // Free count since the latest strobe fall; only read while a page is open
         gap_q <= gap_q + 1'b1;
         case (state_q)
            S_PWRUP:
               if (rd_ok)
                  state_q <= S_IDLE;
            S_IDLE:
            begin
               tm_q <= '0;
               if (req_ready && req_write)
               begin
                  // Address stable before select and strobe fall
                  mem_address <= req_addr;
                  data_out <= req_wdata;
                  data_oe <= 1'b1;
                  output_drive_enable_n <= 1'b1;
                  last_q <= req_last;
                  state_q <= S_WSET;
               end
               else if (req_ready)
               begin
                  mem_address <= req_addr;
                  chip_select_n <= 1'b0;
                  output_drive_enable_n <= 1'b0;
                  state_q <= S_RD;
               end
               else if (in_page_q && gap_expired)
               begin
                  // Host stops loading; device closes page by itself
                  in_page_q <= 1'b0;
                  state_q <= S_PROG;
               end
            end
            S_RD:
               if (tm_q == CNT_W'(RD_CYC + 2))
               begin
                  chip_select_n <= 1'b1;
                  output_drive_enable_n <= 1'b1;
                  rsp_valid <= 1'b1;
                  rsp_rdata <= din_q;
                  state_q <= in_page_q ? S_IDLE : S_IDLE;
               end
            S_WSET:
               if (tm_q == CNT_W'(OES_CYC))
               begin
                  chip_select_n <= 1'b0;
                  write_strobe_n <= 1'b0;
                  gap_q <= '0;
                  tm_q <= '0;
                  state_q <= S_WLOW;
               end
            S_WLOW:
               if (tm_q == CNT_W'(WP_CYC))
               begin
                  write_strobe_n <= 1'b1;
                  chip_select_n <= 1'b1;
                  tm_q <= '0;
                  state_q <= S_WHIGH;
               end
            S_WHIGH:
               if (tm_q == CNT_W'(WPH_CYC))
               begin
                  data_oe <= 1'b0;
                  tm_q <= '0;
                  if (last_q || nbytes_q == 9'(PAGE_BYTES - 1))
                  begin
                     in_page_q <= 1'b0;
                     nbytes_q <= '0;
                     state_q <= S_PROG;
                  end
                  else
                  begin
                     in_page_q <= 1'b1;
                     page_q <= mem_address[ADDR_W-1:8];
                     nbytes_q <= nbytes_q + 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            S_PROG:
            begin
               nbytes_q <= '0;
               // Full program time wait, no polling needed
               if (tm_q >= CNT_W'(PROG_CYCLES + BLC_MAX_CYC))
               begin
                  prog_done <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default:
               state_q <= S_PWRUP;
         endcase
      end
   end

   a_read_drive: assert property (@(posedge clk) disable iff (rst)
      !output_drive_enable_n |-> !chip_select_n && write_strobe_n && !data_oe)
      else $error("read with bad controls");
   a_write_ctl: assert property (@(posedge clk) disable iff (rst)
      !write_strobe_n |-> !chip_select_n && output_drive_enable_n && data_oe)
      else $error("write with bad controls");
   a_strobe_width: assert property (@(posedge clk) disable iff (rst)
      $fell(write_strobe_n) && clk_en |-> !write_strobe_n [*2])
      else $error("strobe too short");
   a_pwr_write: assert property (@(posedge clk) disable iff (rst)
      !write_strobe_n |-> pwr_q >= CNT_W'(PUW_CYCLES))
      else $error("write before power-up delay");
   a_pwr_read: assert property (@(posedge clk) disable iff (rst)
      !output_drive_enable_n |-> pwr_q >= CNT_W'(PUR_CYC))
      else $error("read before power-up delay");
   a_page_bits: assert property (@(posedge clk) disable iff (rst)
      $fell(write_strobe_n) && in_page_q |-> mem_address[ADDR_W-1:8] == page_q)
      else $error("page address changed");
   a_gap_bound: assert property (@(posedge clk) disable iff (rst)
      in_page_q |-> gap_q < CNT_W'(BLC_MAX_CYC))
      else $error("byte load gap too long");
   a_standby_idle: assert property (@(posedge clk) disable iff (rst)
      chip_select_n |-> write_strobe_n && output_drive_enable_n)
      else $error("strobe active while deselected");
endmodule : eeprom_host

// [verif/eeprom_model.sv]
// Behavioural byte-wide nonvolatile memory facing the host controller
`timescale 1ns/1ps
module eeprom_model
   import eeprom_host_pkg::*;
#(
   parameter int PROG_NS = 2000,
   parameter int BLC_NS = 200000
)(
   input wire logic chip_select_n,
   input wire logic output_drive_enable_n,
   input wire logic write_strobe_n,
   input wire logic [ADDR_W-1:0] mem_address,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   output logic [DATA_W-1:0] data_in,
   output logic fault
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [ADDR_W-1:0] adr;
   logic [DATA_W-1:0] last;
   logic prog = 1'b0;
   logic open_q = 1'b0;
   logic tog = 1'b0;
   realtime t_fall;
   wire wr_en = !chip_select_n && !write_strobe_n && output_drive_enable_n;
   wire rd_en = !chip_select_n && !output_drive_enable_n && write_strobe_n;
   initial fault = 1'b0;
   initial data_in = 8'h5a;
   // Address on the later falling edge; page change or busy write is a fault
   always @(posedge wr_en)
   begin
      if (prog || (open_q && mem_address[ADDR_W-1:8] != adr[ADDR_W-1:8]))
         fault = 1'b1;
      adr = mem_address;
      t_fall = $realtime;
      open_q = 1'b1;
   end
   // Data on the first rising edge
   always @(negedge wr_en)
   begin
      // Skip the start-up transition, before any address was taken
      if (open_q)
      begin
         mem[adr] = data_out;
         last = data_out;
      end
   end
   // Strobe gap closes the page, then one programming cycle
   always #10
      if (open_q && $realtime - t_fall >= BLC_NS)
      begin
         open_q = 1'b0;
         prog = 1'b1;
         #(PROG_NS) prog = 1'b0;
      end
   // Each read flips bit 6 while programming
   always @(posedge rd_en)
      if (prog)
         tog = ~tog;
   // Wire level: host drive, device read, or released bus showing a changing pattern
   always @(rd_en, prog, tog, data_oe, data_out, mem_address)
      if (data_oe)
         data_in = data_out;
      else if (!rd_en)
         data_in = ~data_in;
      else if (prog)
         data_in = {~last[7], tog, last[5:0]};
      else
         data_in = mem.exists(mem_address) ? mem[mem_address] : 8'hff;
endmodule : eeprom_model

// [verif/tb_top.sv]
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
module tb_top;
   import eeprom_host_pkg::*;
   localparam int LIMIT = 60000;
   localparam int PROG_T = 100;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_last = 1'b0;
   logic req_poll = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic req_ready, rsp_valid, busy, prog_done, chip_select_n, output_drive_enable_n, write_strobe_n, data_oe, fault;
   logic [DATA_W-1:0] rsp_rdata, data_out, data_in, got;
   logic [ADDR_W-1:0] mem_address;
   logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];
   logic [8:0] pg;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed = 40799;
   // Clock at 20 MHz
   always #25 clk = ~clk;
   eeprom_host #(.PUW_CYCLES(50), .PROG_CYCLES(PROG_T)) DUT (.clk(clk), .rst(rst), .clk_en(clk_en),
      .req_valid(req_valid), .req_write(req_write), .req_last(req_last), .req_poll(req_poll), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
      .prog_done(prog_done), .chip_select_n(chip_select_n), .output_drive_enable_n(output_drive_enable_n),
      .write_strobe_n(write_strobe_n), .mem_address(mem_address), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in));
   eeprom_model peer (.chip_select_n(chip_select_n), .output_drive_enable_n(output_drive_enable_n),
      .write_strobe_n(write_strobe_n), .mem_address(mem_address), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .fault(fault));
   // Verdict and end of run
   task automatic conclude();
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // One comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Expected byte at an address
   function automatic logic [DATA_W-1:0] expect_at(input logic [ADDR_W-1:0] a);
      return exp_mem.exists(a) ? exp_mem[a] : 8'hff;
   endfunction : expect_at
   // One request held until taken; reads wait for the answer
   task automatic op(input logic w, input logic l, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_last <= l;
      req_poll <= !w && (busy || ($random(seed) % 2 != 0));
      req_addr <= a;
      req_wdata <= d;
      do
         @(posedge clk);
      while (!(req_ready === 1'b1 && clk_en) && ++n < 5000);
      req_valid <= 1'b0;
      chk("req_taken", 1, n < 5000);
      if (w)
         exp_mem[a] = d;
      n = 0;
      if (!w)
      begin
         do
            @(posedge clk);
         while (rsp_valid !== 1'b1 && ++n < 100);
         got = rsp_rdata;
         chk("read_answer", 1, rsp_valid);
      end
   endtask : op
   // Freeze, then wait out programming and the device's load window
   task automatic settle();
      int n;
      clk_en <= 1'b0;
      repeat (30) @(posedge clk);
      clk_en <= 1'b1;
      n = 30;
      do
         @(posedge clk);
      while (prog_done !== 1'b1 && ++n < 13000);
      chk("prog_wait", 1, n >= PROG_T + BLC_MAX_CYC + 30 && n < 13000);
      repeat (BLC_MAX_CYC + 100) @(posedge clk);
   endtask : settle
   // Pin discipline while selected, and the run limit
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         failures++;
         conclude();
      end
      else
      begin
         if (!rst && chip_select_n === 1'b0 && write_strobe_n === 1'b0)
            chk("write_pins", 2'b11, {output_drive_enable_n, data_oe});
         if (!rst && chip_select_n === 1'b0 && output_drive_enable_n === 1'b0)
            chk("read_drive", 0, data_oe);
      end
   end
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      req_valid <= 1'b1;
      req_write <= 1'b1;
      repeat (PUR_CYC - 4) @(posedge clk);
      chk("ready_powerup", 0, req_ready);
      chk("idle_select", 1, chip_select_n);
      pg = 9'($random(seed));
      for (int i = 0; i < PAGE_BYTES; i++)
         op(1'b1, i == PAGE_BYTES - 1, {pg, i[7:0]}, 8'($random(seed)));
      settle();
      pg = pg + 9'h1;
      op(1'b1, 1'b0, {pg, 8'h00}, 8'h00);
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr <= {pg + 9'h1, 8'h01};
      repeat (16) @(posedge clk) chk("other_page", 0, req_ready);
      req_valid <= 1'b0;
      op(1'b0, 1'b0, {pg, 8'h00}, 8'h00);
      chk("poll_read", expect_at({pg, 8'h00}), got);
      op(1'b1, 1'b1, {pg, 8'hff}, 8'hff);
      settle();
      op(1'b1, 1'b0, 17'($random(seed)), 8'($random(seed)));
      settle();
      foreach (exp_mem[a])
      begin
         op(1'b0, 1'b0, a, 8'h00);
         chk("read_byte", expect_at(a), got);
      end
      chk("device_fault", 0, fault);
      conclude();
   end
endmodule : tb_top
